//--- eirq_ctrl.sv
`timescale 1ns/1ps
// What this block does
// RQ1 - High priority input beats every other source.
// RQ2 - Per input edge or level select bit.
// RQ3 - Rising edge or active high sensing.
// RQ4 - Edge mode samples at phase four.
// RQ5 - Requester holds levels one machine cycle.
// RQ6 - Edge flag cleared on vectoring.
// RQ7 - Level requester holds input until serviced.
// RQ8 - Level flag kept on routine entry.
// RQ9 - Flags update at phase three.
// RQ10 - New flag polled next machine cycle.
// RQ11 - Hardware call takes four machine cycles.
// RQ12 - Minimum latency five machine cycles.
// RQ13 - Vectoring delayed by three blocking conditions.
// RQ14 - Single interrupt latency at most twelve cycles.
// RQ15 - Worst budget: detect, register, multiply, call.
// RQ16 - Response time may stretch with stalls.
// RQ17 - Call loads the source's fixed vector.
// RQ18 - Blocked requests are not remembered.
// RQ19 - Only return from interrupt ends service.
// RQ20 - Inputs pass a two stage synchroniser.
// RQ21 - Level flag follows synchronised input.
module eirq_ctrl
  import eirq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Request sideband inputs
  input wire logic high_priority_irq_in_i,
  input wire logic ext_irq_in_zero_i,
  input wire logic ext_irq_in_one_i,
  // Processor sequencer
  input wire logic last_cycle_i,
  input wire logic irq_reg_write_i,
  input wire logic return_from_irq_i,
  input wire logic high_priority_clear_i,
  // Call to sequencer
  output logic call_start_o,
  output logic call_busy_o,
  output logic [15:0] call_vector_o,
  output logic routine_start_o,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  logic [2:0] raw_in;
  logic [2:0] sync_in;
  logic [1:0] phase_ff;
  logic [1:0] prev_sample_ff;
  logic [1:0] last_sample_ff;
  logic high_priority_flag_ff;
  logic ext_request_flag_zero_ff;
  logic ext_request_flag_one_ff;
  logic [2:0] fresh_ff;
  logic [4:0] timer_control_reg_ff;
  eirq_state_t state_ff;
  eirq_state_t nxt_state;
  logic [2:0] call_cnt_ff;
  logic [1:0] src_ff;
  logic [1:0] nxt_src;
  logic [1:0] srv_lvl_ff;
  logic [1:0] nxt_lvl;
  logic [2:0] pend;
  logic [1:0] lvl_of [3];
  logic take;
  logic [15:0] call_vector_ff;
  logic call_start_ff;
  logic routine_start_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic mc_end;
  logic [1:0] edge_sel;

  assign raw_in = {ext_irq_in_one_i, ext_irq_in_zero_i, high_priority_irq_in_i};
  assign mc_end = (phase_ff == PH_FOUR);
  assign edge_sel = timer_control_reg_ff[CTRL_EDGE_ONE:CTRL_EDGE_ZERO];

  eirq_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i(raw_in), // [RQ20]
    .sync_o(sync_in)
  );

  // Phase counter; four clocks per machine cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_ff <= PH_ONE;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // Phase four samples of the general inputs; the last two are kept for edge detection.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      last_sample_ff <= 2'h0;
      prev_sample_ff <= 2'h0;
    end else if (phase_ff == PH_FOUR) begin
      last_sample_ff <= sync_in[2:1]; // [RQ4]
      prev_sample_ff <= last_sample_ff;
    end
  end

  // Edge seen: one phase-four sample low and the next one high. It stands for a whole
  // machine cycle, so exactly one phase-three update acts on it.
  logic [1:0] rise;
  assign rise = last_sample_ff & ~prev_sample_ff; // [RQ3]

  // Clearing by vectoring for the source being called.
  logic clr_zero;
  logic clr_one;
  assign clr_zero = take && (nxt_src == SRC_ZERO[1:0]) && edge_sel[0]; // [RQ6]
  assign clr_one = take && (nxt_src == SRC_ONE[1:0]) && edge_sel[1]; // [RQ6]

  // General request flags: set wins over clear in edge mode.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_request_flag_zero_ff <= 1'b0;
    end else if (phase_ff == PH_THREE) begin
      if (edge_sel[0]) begin // [RQ2]
        if (rise[0]) begin
          ext_request_flag_zero_ff <= 1'b1; // [RQ9]
        end else if (clr_zero) begin
          ext_request_flag_zero_ff <= 1'b0;
        end
      end else begin
        ext_request_flag_zero_ff <= sync_in[1]; // [RQ21] [RQ8]
      end
    end else if (clr_zero) begin
      ext_request_flag_zero_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_request_flag_one_ff <= 1'b0;
    end else if (phase_ff == PH_THREE) begin
      if (edge_sel[1]) begin // [RQ2]
        if (rise[1]) begin
          ext_request_flag_one_ff <= 1'b1; // [RQ9]
        end else if (clr_one) begin
          ext_request_flag_one_ff <= 1'b0;
        end
      end else begin
        ext_request_flag_one_ff <= sync_in[2]; // [RQ21] [RQ8]
      end
    end else if (clr_one) begin
      ext_request_flag_one_ff <= 1'b0;
    end
  end

  // High priority flag: set by the input, cleared by software; set wins.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      high_priority_flag_ff <= 1'b0;
    end else if (phase_ff == PH_THREE && sync_in[0]) begin
      high_priority_flag_ff <= 1'b1; // [RQ9]
    end else if (high_priority_clear_i) begin
      high_priority_flag_ff <= 1'b0;
    end
  end

  // Flags set in this machine cycle are held back until the next one.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fresh_ff <= 3'h0;
    end else if (phase_ff == PH_THREE) begin
      fresh_ff <= {ext_request_flag_one_ff, ext_request_flag_zero_ff, high_priority_flag_ff};
    end
  end

  // Levels: 3 for high priority, 2 for raised, 1 for normal, 0 none in service.
  assign lvl_of[SRC_HP] = 2'h3; // [RQ1]
  assign lvl_of[SRC_ZERO] = timer_control_reg_ff[CTRL_PRI_ZERO] ? 2'h2 : 2'h1;
  assign lvl_of[SRC_ONE] = timer_control_reg_ff[CTRL_PRI_ONE] ? 2'h2 : 2'h1;

  // Polling is live only; nothing is remembered across blocked cycles.
  assign pend = fresh_ff & {ext_request_flag_one_ff, ext_request_flag_zero_ff,
                            high_priority_flag_ff}; // [RQ10] [RQ18]

  always_comb begin
    nxt_src = SRC_HP[1:0];
    nxt_lvl = 2'h0;
    take = 1'b0;
    // Higher level wins; inside one level the lower index wins.
    for (int i = 2; i >= 0; i--) begin
      if (pend[i] && lvl_of[i] >= nxt_lvl) begin
        nxt_src = 2'(i);
        nxt_lvl = lvl_of[i];
      end
    end
    if (pend != 3'h0 && state_ff == EIRQ_IDLE && mc_end
        && timer_control_reg_ff[CTRL_ENABLE]
        && nxt_lvl > srv_lvl_ff && last_cycle_i
        && !irq_reg_write_i && !return_from_irq_i) begin
      take = 1'b1; // [RQ13] [RQ14] [RQ15] [RQ16]
    end
  end

  // Call sequencer.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      EIRQ_IDLE: if (take) nxt_state = EIRQ_CALL;
      EIRQ_CALL: if (mc_end && call_cnt_ff == CALL_MCS - 3'h1) nxt_state = EIRQ_SERV; // [RQ11]
      EIRQ_SERV: nxt_state = EIRQ_IDLE;
      default: nxt_state = EIRQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff <= EIRQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      call_cnt_ff <= 3'h0;
    end else if (state_ff != EIRQ_CALL) begin
      call_cnt_ff <= 3'h0;
    end else if (mc_end) begin
      call_cnt_ff <= call_cnt_ff + 3'h1; // [RQ11] [RQ12]
    end
  end

  // Level in service; only the return from interrupt ends it.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      srv_lvl_ff <= 2'h0;
      src_ff <= 2'h0;
    end else if (take) begin
      srv_lvl_ff <= nxt_lvl;
      src_ff <= nxt_src;
    end else if (return_from_irq_i && state_ff == EIRQ_IDLE) begin
      srv_lvl_ff <= 2'h0; // [RQ19]
    end
  end

  // Outputs to the sequencer.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      call_start_ff <= 1'b0;
      routine_start_ff <= 1'b0;
      call_vector_ff <= 16'h0000;
    end else begin
      call_start_ff <= take;
      routine_start_ff <= (state_ff == EIRQ_CALL) && (nxt_state == EIRQ_SERV);
      if (take) begin
        unique case (nxt_src)
          2'h0: call_vector_ff <= VEC_HIGH_PRI; // [RQ17]
          2'h1: call_vector_ff <= VEC_EXT_ZERO; // [RQ17]
          2'h2: call_vector_ff <= VEC_EXT_ONE; // [RQ17]
          default: call_vector_ff <= 16'h0000;
        endcase
      end
    end
  end

  assign call_start_o = call_start_ff;
  assign routine_start_o = routine_start_ff;
  assign call_vector_o = call_vector_ff;
  assign call_busy_o = state_ff[1];

  // APB slave, zero wait states.
  logic apb_acc;
  logic apb_hit;
  // A write lands at the access edge at which pready is seen high.
  assign apb_acc = psel_i && penable_i && pready_ff;
  assign apb_hit = (paddr_i == OFS_CTRL) || (paddr_i == OFS_STAT) || (paddr_i == OFS_VEC);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_control_reg_ff <= CTRL_RESET;
    end else if (apb_acc && pwrite_i && paddr_i == OFS_CTRL) begin
      timer_control_reg_ff <= pwdata_i[4:0]; // [RQ2]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel_i && !penable_i;
      pslverr_ff <= psel_i && !penable_i && !apb_hit;
      prdata_ff <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
        unique case (paddr_i)
          OFS_CTRL: prdata_ff <= {27'h0, timer_control_reg_ff};
          OFS_STAT: prdata_ff <= {24'h0, srv_lvl_ff, state_ff, ext_request_flag_one_ff,
                                  ext_request_flag_zero_ff, high_priority_flag_ff};
          OFS_VEC: prdata_ff <= {16'h0, call_vector_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign prdata_o = prdata_ff;

  // Checks.
  hp_first_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ1]
    take && pend[0] |-> nxt_src == 2'h0)
    else $error("high priority source not chosen");

  edge_set_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ4]
    phase_ff == PH_THREE && edge_sel[0] && rise[0] |=> ext_request_flag_zero_ff)
    else $error("edge flag zero not set");

  level_follow_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ21]
    phase_ff == PH_THREE && !edge_sel[1] |=> ext_request_flag_one_ff == $past(sync_in[2]))
    else $error("level flag one does not follow input");

  edge_clear_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ6]
    clr_zero && !(phase_ff == PH_THREE && rise[0]) |=> !ext_request_flag_zero_ff)
    else $error("edge flag not cleared on vectoring");

  call_len_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ11]
    take |=> (state_ff == EIRQ_CALL) [*8] ##1 (state_ff == EIRQ_CALL) [*8]
    ##1 state_ff == EIRQ_SERV)
    else $error("call did not last four machine cycles");

  vec_load_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ17]
    take && nxt_src == 2'h1 |=> call_vector_o == 16'h0003)
    else $error("wrong vector for source zero");

  block_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ13]
    irq_reg_write_i || !last_cycle_i |-> !take)
    else $error("vectoring during blocked cycle");

  no_fresh_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ10]
    $rose(ext_request_flag_one_ff) |-> (!(take && nxt_src == SRC_ONE[1:0])) [*4])
    else $error("flag acted on in the cycle it was set");

  return_from_irq_a: assert property (@(posedge clk_i) disable iff (srst_i) // [RQ19]
    srv_lvl_ff != 2'h0 && !return_from_irq_i && !take |=> srv_lvl_ff == $past(srv_lvl_ff))
    else $error("service level dropped without return");

endmodule // eirq_ctrl

//--- eirq_pkg.sv
package eirq_pkg;

  // Four bus clocks make one machine cycle.
  localparam int unsigned CLKS_PER_MC = 4;
  // Phase numbers within a machine cycle, 0 based on the phase counter.
  localparam logic [1:0] PH_ONE = 2'h0;
  localparam logic [1:0] PH_THREE = 2'h2;
  localparam logic [1:0] PH_FOUR = 2'h3;
  // Machine cycles taken by the hardware subroutine call.
  localparam logic [2:0] CALL_MCS = 3'h4;
  // Latency figures in machine cycles and in clocks.
  localparam int unsigned MIN_LAT_MC = 5;
  localparam int unsigned MAX_LAT_MC = 12;
  localparam int unsigned MIN_LAT_CLKS = MIN_LAT_MC * CLKS_PER_MC;
  localparam int unsigned MAX_LAT_CLKS = MAX_LAT_MC * CLKS_PER_MC;
  // Worst case budget parts.
  localparam int unsigned DET_MC = 1;
  localparam int unsigned REG_ACC_MC = 2;
  localparam int unsigned MULDIV_MC = 5;
  // Vector addresses.
  localparam logic [15:0] VEC_EXT_ZERO = 16'h0003;
  localparam logic [15:0] VEC_EXT_ONE = 16'h0013;
  localparam logic [15:0] VEC_HIGH_PRI = 16'h0033;
  // APB register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_VEC = 8'h08;
  // Control register bits.
  localparam int unsigned CTRL_EDGE_ZERO = 0;
  localparam int unsigned CTRL_EDGE_ONE = 1;
  localparam int unsigned CTRL_PRI_ZERO = 2;
  localparam int unsigned CTRL_PRI_ONE = 3;
  localparam int unsigned CTRL_ENABLE = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // Source indices, in default precedence order.
  localparam int unsigned SRC_HP = 0;
  localparam int unsigned SRC_ZERO = 1;
  localparam int unsigned SRC_ONE = 2;

  typedef enum logic [2:0] {
    EIRQ_IDLE = 3'b001,
    EIRQ_CALL = 3'b010,
    EIRQ_SERV = 3'b100
  } eirq_state_t;

endpackage

//--- eirq_req_model.sv
`timescale 1ns/1ps
module eirq_req_model (
  // Clock
  input wire logic clk_i,
  // Request lines
  output logic high_priority_irq_in_o,
  output logic ext_irq_in_zero_o,
  output logic ext_irq_in_one_o
);
  logic [2:0] lvl_ff = 3'h0;
  assign {ext_irq_in_one_o, ext_irq_in_zero_o, high_priority_irq_in_o} = lvl_ff;
  // Every level is kept for more than one machine cycle so that a sample never misses it.
  task automatic drive(input int idx, input logic val);
    @(posedge clk_i);
    lvl_ff[idx] <= val;
    repeat (5) @(posedge clk_i);
  endtask
endmodule // eirq_req_model

//--- eirq_sync.sv
`timescale 1ns/1ps
module eirq_sync #(
  parameter int unsigned WIDTH = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial begin
    if (WIDTH < 1) $error("eirq_sync needs at least one bit");
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // eirq_sync

//--- ext_irq_sense_and_latency_tb.sv
`timescale 1ns/1ps
module ext_irq_sense_and_latency_tb
  import eirq_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hp_w, irq0_w, irq1_w, pready, pslverr, call_start, call_busy, routine_start, err;
  logic last_cycle = 1'b1, reg_wr = 1'b0, return_from_irq = 1'b0, hp_clr = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, pat;
  logic [15:0] call_vec;
  int errors = 0, compares = 0, cyc = 0, t0 = 0, seed;
  logic [15:0] exp_q[$];

  eirq_req_model u_req (.clk_i(clk_i), .high_priority_irq_in_o(hp_w),
    .ext_irq_in_zero_o(irq0_w), .ext_irq_in_one_o(irq1_w));
  eirq_ctrl u_dut (.clk_i(clk_i), .srst_i(srst_i), .high_priority_irq_in_i(hp_w),
    .ext_irq_in_zero_i(irq0_w), .ext_irq_in_one_i(irq1_w), .last_cycle_i(last_cycle),
    .irq_reg_write_i(reg_wr), .return_from_irq_i(return_from_irq), .high_priority_clear_i(hp_clr),
    .call_start_o(call_start), .call_busy_o(call_busy), .call_vector_o(call_vec),
    .routine_start_o(routine_start), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    chk(pready, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk(err, exp_err);
  endtask

  // Raises the return strobe, or the high priority clear when hp is set, for one edge.
  task automatic pulse(input logic hp);
    @(posedge clk_i);
    if (hp) begin
      hp_clr <= 1'b1;
    end else begin
      return_from_irq <= 1'b1;
    end
    @(posedge clk_i);
    hp_clr <= 1'b0;
    return_from_irq <= 1'b0;
  endtask

  // Expected vector comes from the model queue; latency is judged only for unblocked requests.
  task automatic wait_call(input logic lat);
    int n, busy;
    logic [15:0] vec;
    n = 0;
    busy = 0;
    vec = exp_q.pop_front();
    do begin
      @(negedge clk_i);
      n++;
    end while (call_start !== 1'b1 && n < 120);
    while (n < 240) begin
      if (call_busy === 1'b1) busy++;
      if (routine_start === 1'b1) break;
      @(negedge clk_i);
      n++;
    end
    chk(call_vec, {16'h0000, vec});
    chk(busy, 16);
    if (lat) chk(cyc - t0 >= 20 && cyc - t0 <= 48, 1);
  endtask

  task automatic no_call(input int mcs);
    int hits;
    hits = 0;
    repeat (mcs * 4) begin
      @(negedge clk_i);
      if (call_start !== 1'b0) hits++;
    end
    @(posedge clk_i);
    chk(hits, 0);
  endtask

  initial begin
    seed = $urandom(32'h3593_c838);
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    rd_chk(OFS_CTRL, 32'h0000_0000, 1'b0);
    rd_chk(8'h0C, 32'h0000_0000, 1'b1);
    repeat (4) begin
      pat = $urandom & 32'h0000_001F;
      apb(1'b1, OFS_CTRL, pat);
      rd_chk(OFS_CTRL, pat, 1'b0);
    end
    // Edge mode on both general inputs, rising edge taken, falling edge ignored.
    apb(1'b1, OFS_CTRL, 32'h0000_0013);
    for (int i = 1; i < 3; i++) begin
      exp_q.push_back(i == 1 ? VEC_EXT_ZERO : VEC_EXT_ONE);
      t0 = cyc + 1;
      u_req.drive(i, 1'b1);
      wait_call(1'b1);
      rd_chk(OFS_STAT, {24'h0, 2'h1, 3'h1, 3'h0}, 1'b0);
      chk(rd[i], 1'b0);
      pulse(1'b0);
      u_req.drive(i, 1'b0);
      no_call(3);
    end
    rd_chk(OFS_VEC, {16'h0000, VEC_EXT_ONE}, 1'b0);
    // Level mode, blocked by the sequencer, then retaken after return while held.
    apb(1'b1, OFS_CTRL, 32'h0000_0010);
    last_cycle <= 1'b0;
    u_req.drive(2, 1'b1);
    no_call(4);
    last_cycle <= 1'b1;
    reg_wr <= 1'b1;
    no_call(2);
    reg_wr <= 1'b0;
    exp_q.push_back(VEC_EXT_ONE);
    wait_call(1'b0);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk(rd[2], 1'b1);
    exp_q.push_back(VEC_EXT_ONE);
    pulse(1'b0);
    wait_call(1'b0);
    u_req.drive(2, 1'b0);
    pulse(1'b0);
    repeat (8) @(posedge clk_i);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk(rd[2], 1'b0);
    no_call(3);
    // A level request that goes away while blocked is lost.
    last_cycle <= 1'b0;
    u_req.drive(1, 1'b1);
    u_req.drive(1, 1'b0);
    repeat (8) @(posedge clk_i);
    last_cycle <= 1'b1;
    no_call(4);
    // High priority wins over a pending general request and holds it off.
    last_cycle <= 1'b0;
    u_req.drive(1, 1'b1);
    u_req.drive(0, 1'b1);
    exp_q.push_back(VEC_HIGH_PRI);
    exp_q.push_back(VEC_EXT_ZERO);
    // Give the high priority flag two machine cycles to become pollable first.
    repeat (8) @(posedge clk_i);
    last_cycle <= 1'b1;
    wait_call(1'b0);
    no_call(3);
    u_req.drive(0, 1'b0);
    pulse(1'b1);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk(rd[0], 1'b0);
    pulse(1'b0);
    wait_call(1'b0);
    u_req.drive(1, 1'b0);
    pulse(1'b0);
    no_call(3);
    report_and_stop();
  end
endmodule // ext_irq_sense_and_latency_tb
